// ===== verilog/gpd_pkg.sv
package gpd_pkg;
	// bus geometry
	localparam int APB_ADDR_W = 12;
	localparam int APB_DATA_W = 32;
	localparam int IDX_W = 10;
	localparam int BYTE_W = 8;
	localparam int STRB_W = 4;

	// port widths
	localparam int PORT_D_W = 7;
	localparam int PORT_E_W = 8;
	localparam int PORT_F_W = 4;

	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_PORT_D_DATA = 10'h003;
	localparam logic [IDX_W-1:0] IDX_PORT_E_DATA = 10'h008;
	localparam logic [IDX_W-1:0] IDX_PORT_F_DATA = 10'h009;
	localparam logic [IDX_W-1:0] IDX_PORT_D_DIR = 10'h010;
	localparam logic [IDX_W-1:0] IDX_PORT_E_DIR = 10'h011;
	localparam logic [IDX_W-1:0] IDX_PORT_F_DIR = 10'h012;
	localparam logic [IDX_W-1:0] IDX_PERIPH_CTRL = 10'h014;
	localparam logic [IDX_W-1:0] IDX_TIMER_CHAN = 10'h015;

	// peripheral control register fields
	localparam int ACS_LSB = 0;
	localparam int ACS_W = 5;
	localparam int PS_LSB = 8;
	localparam int PS_W = 3;
	localparam int SPE_BIT = 16;
	localparam int MSTR_BIT = 17;
	localparam int MODE_FAULT_ENABLE_BIT = 18;
	localparam int SCI_BIT = 19;
	localparam int PERIPH_CTRL_W = 20;

	// timer channel edge/level select, two bits per channel
	localparam int ELS_W = 2;
	localparam int TIMER_CHANS = 6;
	localparam int TIMER_CHAN_W = ELS_W * TIMER_CHANS;

	// encodings
	localparam logic [PS_W-1:0] PS_EXT_CLOCK = 3'h7;
	localparam logic [ACS_W-1:0] ACS_FIRST_D = 5'h08;
	localparam logic [ACS_W-1:0] ACS_LAST_D = 5'h0E;
	localparam int D_TIMER_EXTERNAL_CLOCK_PIN_BIT = 6;

	// reset values
	localparam logic [APB_DATA_W-1:0] REG_RESET = 32'h0000_0000;
endpackage

// ===== verilog/gpd_port_bank.sv
`timescale 1ns/1ps
// one port: pin synchroniser, pin driver and read-back mux
module gpd_port_bank #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] pinIn,
	input wire logic [W-1:0] latch,
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] owned,
	input wire logic [W-1:0] readZero,
	input wire logic [W-1:0] periphOut,
	input wire logic [W-1:0] periphDrv,
	output logic [W-1:0] pinOut,
	output logic [W-1:0] pinOeN,
	output logic [W-1:0] pinSync,
	output logic [W-1:0] readVal
);
	logic [W-1:0] pinMeta;
	logic [W-1:0] next_drive;
	logic [W-1:0] next_value;

	// two-stage synchroniser, pinMeta feeds only pinSync
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pinMeta <= '0;
			pinSync <= '0;
		end
		else
		begin
			pinMeta <= pinIn;
			pinSync <= pinMeta;
		end
	end

	// owned pins follow the peripheral, the direction bit only steers reads
	always_comb
	begin
		next_drive = (owned & periphDrv) | (~owned & dir);
		next_value = (owned & periphOut) | (~owned & latch);
	end

	// registered driver; reset leaves every pin undriven
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pinOeN <= '1;
			pinOut <= '0;
		end
		else
		begin
			pinOeN <= ~next_drive;
			pinOut <= next_value & next_drive;
		end
	end

	// output bits read the latch, inputs the synced pin or zero
	always_comb
	begin
		readVal = (dir & latch) | (~dir & ~readZero & pinSync);
	end
endmodule

// ===== verilog/gpd_ports.sv
`timescale 1ns/1ps
module gpd_ports (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [gpd_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [gpd_pkg::APB_DATA_W-1:0] pwdata,
	input wire logic [gpd_pkg::STRB_W-1:0] pstrb,
	output logic [gpd_pkg::APB_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [gpd_pkg::PORT_D_W-1:0] portDPinIn,
	output logic [gpd_pkg::PORT_D_W-1:0] portDPinOut,
	output logic [gpd_pkg::PORT_D_W-1:0] portDPinOeN,
	input wire logic [gpd_pkg::PORT_E_W-1:0] portEPinIn,
	output logic [gpd_pkg::PORT_E_W-1:0] portEPinOut,
	output logic [gpd_pkg::PORT_E_W-1:0] portEPinOeN,
	input wire logic [gpd_pkg::PORT_F_W-1:0] portFPinIn,
	output logic [gpd_pkg::PORT_F_W-1:0] portFPinOut,
	output logic [gpd_pkg::PORT_F_W-1:0] portFPinOeN,
	input wire logic [3:0] spiOut,
	input wire logic [3:0] spiDrv,
	input wire logic [1:0] timerChanOutE,
	input wire logic [1:0] timerChanDrvE,
	input wire logic [gpd_pkg::PORT_F_W-1:0] timerChanOutF,
	input wire logic [gpd_pkg::PORT_F_W-1:0] timerChanDrvF,
	input wire logic sciTxOut,
	output logic [gpd_pkg::PORT_E_W-1:0] portEPinSync,
	output logic [gpd_pkg::PORT_F_W-1:0] portFPinSync,
	output logic timerExtClock,
	output logic [gpd_pkg::ACS_W-1:0] analogChannelSelect,
	output logic [gpd_pkg::PS_W-1:0] timerPrescalerSelect,
	output logic serialPeriphEnable,
	output logic serialPeriphMaster,
	output logic modeFaultEnable,
	output logic asyncSerialEnable,
	output logic [gpd_pkg::TIMER_CHAN_W-1:0] edgeLevelSelect
);
	// byte-lane merge used by every writable register
	function automatic logic [gpd_pkg::APB_DATA_W-1:0] mergeWrite(
		input logic [gpd_pkg::APB_DATA_W-1:0] oldVal,
		input logic [gpd_pkg::APB_DATA_W-1:0] wdata,
		input logic [gpd_pkg::STRB_W-1:0] strb
	);
		logic [gpd_pkg::APB_DATA_W-1:0] res;
		res = oldVal;
		for (int b = 0; b < gpd_pkg::STRB_W; b++)
		begin
			if (strb[b])
			begin
				res[b*gpd_pkg::BYTE_W +: gpd_pkg::BYTE_W] = wdata[b*gpd_pkg::BYTE_W +: gpd_pkg::BYTE_W];
			end
		end
		return res;
	endfunction

	// one-hot port D bit for an analog channel select value
	function automatic logic [gpd_pkg::PORT_D_W-1:0] analogMask(
		input logic [gpd_pkg::ACS_W-1:0] sel
	);
		logic [gpd_pkg::PORT_D_W-1:0] m;
		logic [gpd_pkg::ACS_W-1:0] ofs;
		m = '0;
		ofs = sel - gpd_pkg::ACS_FIRST_D;
		if (sel >= gpd_pkg::ACS_FIRST_D && sel <= gpd_pkg::ACS_LAST_D)
		begin
			m[ofs[2:0]] = 1'b1;
		end
		return m;
	endfunction

	// true when a timer channel's edge/level select is nonzero
	function automatic logic chanActive(
		input logic [gpd_pkg::TIMER_CHAN_W-1:0] els,
		input int ch
	);
		return |els[ch*gpd_pkg::ELS_W +: gpd_pkg::ELS_W];
	endfunction

	logic [gpd_pkg::PORT_D_W-1:0] latchD;
	logic [gpd_pkg::PORT_E_W-1:0] latchE;
	logic [gpd_pkg::PORT_F_W-1:0] latchF;
	logic [gpd_pkg::PORT_D_W-1:0] dirD;
	logic [gpd_pkg::PORT_E_W-1:0] dirE;
	logic [gpd_pkg::PORT_F_W-1:0] dirF;
	logic [gpd_pkg::PERIPH_CTRL_W-1:0] periphCtrl;
	logic [gpd_pkg::TIMER_CHAN_W-1:0] timerChan;
	logic [gpd_pkg::PORT_D_W-1:0] ownedD;
	logic [gpd_pkg::PORT_E_W-1:0] ownedE;
	logic [gpd_pkg::PORT_F_W-1:0] ownedF;
	logic [gpd_pkg::PORT_E_W-1:0] periphOutE;
	logic [gpd_pkg::PORT_E_W-1:0] periphDrvE;
	logic [gpd_pkg::PORT_D_W-1:0] readD;
	logic [gpd_pkg::PORT_E_W-1:0] readE;
	logic [gpd_pkg::PORT_F_W-1:0] readF;
	logic [gpd_pkg::PORT_D_W-1:0] syncD;
	logic [gpd_pkg::IDX_W-1:0] regIdx;
	logic mapped;
	logic setupCycle;
	logic writeDone;
	logic spiOn;
	logic ssOwned;
	logic extClkSel;
	logic [gpd_pkg::APB_DATA_W-1:0] next_rdata;

	// bus decode; the low two address bits must be zero
	always_comb
	begin
		regIdx = paddr[gpd_pkg::APB_ADDR_W-1:2];
		setupCycle = psel && !penable;
		writeDone = psel && penable && pready && pwrite && !pslverr;
		mapped = (paddr[1:0] == 2'h0) &&
			(regIdx == gpd_pkg::IDX_PORT_D_DATA || regIdx == gpd_pkg::IDX_PORT_E_DATA ||
			regIdx == gpd_pkg::IDX_PORT_F_DATA || regIdx == gpd_pkg::IDX_PORT_D_DIR ||
			regIdx == gpd_pkg::IDX_PORT_E_DIR || regIdx == gpd_pkg::IDX_PORT_F_DIR ||
			regIdx == gpd_pkg::IDX_PERIPH_CTRL || regIdx == gpd_pkg::IDX_TIMER_CHAN);
	end

	// one wait-free access: ready in the first access cycle
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setupCycle;
			pslverr <= setupCycle && !mapped;
		end
	end

	// data latches carry no reset, so reset keeps whatever was written
	always_ff @(posedge clk)
	begin
		if (writeDone && regIdx == gpd_pkg::IDX_PORT_D_DATA)
		begin
			latchD <= (gpd_pkg::PORT_D_W)'(mergeWrite((gpd_pkg::APB_DATA_W)'(latchD), pwdata, pstrb));
		end
		if (writeDone && regIdx == gpd_pkg::IDX_PORT_E_DATA)
		begin
			latchE <= (gpd_pkg::PORT_E_W)'(mergeWrite((gpd_pkg::APB_DATA_W)'(latchE), pwdata, pstrb));
		end
		if (writeDone && regIdx == gpd_pkg::IDX_PORT_F_DATA)
		begin
			latchF <= (gpd_pkg::PORT_F_W)'(mergeWrite((gpd_pkg::APB_DATA_W)'(latchF), pwdata, pstrb));
		end
	end

	// direction registers, all inputs after reset
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			dirD <= gpd_pkg::REG_RESET[gpd_pkg::PORT_D_W-1:0];
			dirE <= gpd_pkg::REG_RESET[gpd_pkg::PORT_E_W-1:0];
			dirF <= gpd_pkg::REG_RESET[gpd_pkg::PORT_F_W-1:0];
		end
		else
		begin
			if (writeDone && regIdx == gpd_pkg::IDX_PORT_D_DIR)
			begin
				dirD <= (gpd_pkg::PORT_D_W)'(mergeWrite((gpd_pkg::APB_DATA_W)'(dirD), pwdata, pstrb));
			end
			if (writeDone && regIdx == gpd_pkg::IDX_PORT_E_DIR)
			begin
				dirE <= (gpd_pkg::PORT_E_W)'(mergeWrite((gpd_pkg::APB_DATA_W)'(dirE), pwdata, pstrb));
			end
			if (writeDone && regIdx == gpd_pkg::IDX_PORT_F_DIR)
			begin
				dirF <= (gpd_pkg::PORT_F_W)'(mergeWrite((gpd_pkg::APB_DATA_W)'(dirF), pwdata, pstrb));
			end
		end
	end

	// pin-sharing controls, all peripherals released after reset
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			periphCtrl <= gpd_pkg::REG_RESET[gpd_pkg::PERIPH_CTRL_W-1:0];
			timerChan <= gpd_pkg::REG_RESET[gpd_pkg::TIMER_CHAN_W-1:0];
		end
		else
		begin
			if (writeDone && regIdx == gpd_pkg::IDX_PERIPH_CTRL)
			begin
				periphCtrl <= (gpd_pkg::PERIPH_CTRL_W)'(mergeWrite(
					(gpd_pkg::APB_DATA_W)'(periphCtrl), pwdata, pstrb));
			end
			if (writeDone && regIdx == gpd_pkg::IDX_TIMER_CHAN)
			begin
				timerChan <= (gpd_pkg::TIMER_CHAN_W)'(mergeWrite(
					(gpd_pkg::APB_DATA_W)'(timerChan), pwdata, pstrb));
			end
		end
	end

	// pin ownership per port
	always_comb
	begin
		spiOn = periphCtrl[gpd_pkg::SPE_BIT];
		extClkSel = periphCtrl[gpd_pkg::PS_LSB +: gpd_pkg::PS_W] == gpd_pkg::PS_EXT_CLOCK;
		// slave select is free when off, or master without mode-fault check
		ssOwned = spiOn && !(periphCtrl[gpd_pkg::MSTR_BIT] &&
			!periphCtrl[gpd_pkg::MODE_FAULT_ENABLE_BIT]);
		ownedD = analogMask(periphCtrl[gpd_pkg::ACS_LSB +: gpd_pkg::ACS_W]);
		ownedD[gpd_pkg::D_TIMER_EXTERNAL_CLOCK_PIN_BIT] = ownedD[gpd_pkg::D_TIMER_EXTERNAL_CLOCK_PIN_BIT] || extClkSel;
		ownedE[7:5] = {3{spiOn}};
		ownedE[4] = ssOwned;
		ownedE[3] = chanActive(timerChan, 1);
		ownedE[2] = chanActive(timerChan, 0);
		ownedE[1:0] = {2{periphCtrl[gpd_pkg::SCI_BIT]}};
		for (int i = 0; i < gpd_pkg::PORT_F_W; i++)
		begin
			ownedF[i] = chanActive(timerChan, i + 2);
		end
		// receive pin is a pure input, transmit always drives while owned
		periphOutE = {spiOut, timerChanOutE, 1'b0, sciTxOut};
		periphDrvE = {spiDrv, timerChanDrvE, 1'b0, 1'b1};
	end

	// port D pins taken by converter or timer clock are inputs only
	gpd_port_bank #(
		.W(gpd_pkg::PORT_D_W)
	) bankD (
		.clk(clk),
		.rstn(rstn),
		.pinIn(portDPinIn),
		.latch(latchD),
		.dir(dirD),
		.owned(ownedD),
		.readZero(ownedD),
		.periphOut('0),
		.periphDrv('0),
		.pinOut(portDPinOut),
		.pinOeN(portDPinOeN),
		.pinSync(syncD),
		.readVal(readD)
	);

	gpd_port_bank #(
		.W(gpd_pkg::PORT_E_W)
	) bankE (
		.clk(clk),
		.rstn(rstn),
		.pinIn(portEPinIn),
		.latch(latchE),
		.dir(dirE),
		.owned(ownedE),
		.readZero('0),
		.periphOut(periphOutE),
		.periphDrv(periphDrvE),
		.pinOut(portEPinOut),
		.pinOeN(portEPinOeN),
		.pinSync(portEPinSync),
		.readVal(readE)
	);

	gpd_port_bank #(
		.W(gpd_pkg::PORT_F_W)
	) bankF (
		.clk(clk),
		.rstn(rstn),
		.pinIn(portFPinIn),
		.latch(latchF),
		.dir(dirF),
		.owned(ownedF),
		.readZero('0),
		.periphOut(timerChanOutF),
		.periphDrv(timerChanDrvF),
		.pinOut(portFPinOut),
		.pinOeN(portFPinOeN),
		.pinSync(portFPinSync),
		.readVal(readF)
	);

	// read mux, unused upper bits read zero
	always_comb
	begin
		next_rdata = '0;
		unique case (regIdx)
			gpd_pkg::IDX_PORT_D_DATA: next_rdata[gpd_pkg::PORT_D_W-1:0] = readD;
			gpd_pkg::IDX_PORT_E_DATA: next_rdata[gpd_pkg::PORT_E_W-1:0] = readE;
			gpd_pkg::IDX_PORT_F_DATA: next_rdata[gpd_pkg::PORT_F_W-1:0] = readF;
			gpd_pkg::IDX_PORT_D_DIR: next_rdata[gpd_pkg::PORT_D_W-1:0] = dirD;
			gpd_pkg::IDX_PORT_E_DIR: next_rdata[gpd_pkg::PORT_E_W-1:0] = dirE;
			gpd_pkg::IDX_PORT_F_DIR: next_rdata[gpd_pkg::PORT_F_W-1:0] = dirF;
			gpd_pkg::IDX_PERIPH_CTRL: next_rdata[gpd_pkg::PERIPH_CTRL_W-1:0] = periphCtrl;
			gpd_pkg::IDX_TIMER_CHAN: next_rdata[gpd_pkg::TIMER_CHAN_W-1:0] = timerChan;
			default: next_rdata = '0;
		endcase
	end

	// read data captured at the setup edge, held through the access cycle
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			prdata <= '0;
		end
		else if (setupCycle)
		begin
			prdata <= (mapped && !pwrite) ? next_rdata : '0;
		end
	end

	// controls and timer clock handed to the sharing peripherals
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			timerExtClock <= 1'b0;
			analogChannelSelect <= '0;
			timerPrescalerSelect <= '0;
			serialPeriphEnable <= 1'b0;
			serialPeriphMaster <= 1'b0;
			modeFaultEnable <= 1'b0;
			asyncSerialEnable <= 1'b0;
			edgeLevelSelect <= '0;
		end
		else
		begin
			timerExtClock <= extClkSel && syncD[gpd_pkg::D_TIMER_EXTERNAL_CLOCK_PIN_BIT];
			analogChannelSelect <= periphCtrl[gpd_pkg::ACS_LSB +: gpd_pkg::ACS_W];
			timerPrescalerSelect <= periphCtrl[gpd_pkg::PS_LSB +: gpd_pkg::PS_W];
			serialPeriphEnable <= periphCtrl[gpd_pkg::SPE_BIT];
			serialPeriphMaster <= periphCtrl[gpd_pkg::MSTR_BIT];
			modeFaultEnable <= periphCtrl[gpd_pkg::MODE_FAULT_ENABLE_BIT];
			asyncSerialEnable <= periphCtrl[gpd_pkg::SCI_BIT];
			edgeLevelSelect <= timerChan;
		end
	end

	sequence setupSeen;
		psel && !penable;
	endsequence

	sequence readSetup(logic [gpd_pkg::IDX_W-1:0] idx);
		psel && !penable && !pwrite && paddr[1:0] == 2'h0 && regIdx == idx;
	endsequence

	// bus handshake
	apb_ready_a: assert property (@(posedge clk) disable iff (!rstn)
		setupSeen |=> pready ##1 !pready)
		else $error("ready not one cycle after setup");
	unmapped_err_a: assert property (@(posedge clk) disable iff (!rstn)
		setupSeen and (!mapped) |=> pslverr && pready && prdata == '0)
		else $error("unmapped access not flagged");

	// direction reset
	dir_reset_a: assert property (@(posedge clk)
		!rstn |=> dirD == '0 && dirE == '0 && dirF == '0)
		else $error("direction not cleared by reset");

	// latch write and read back
	latch_write_a: assert property (@(posedge clk) disable iff (!rstn)
		writeDone && regIdx == gpd_pkg::IDX_PORT_D_DATA && pstrb[0]
		|=> latchD == $past(pwdata[gpd_pkg::PORT_D_W-1:0]))
		else $error("port D latch not written");
	read_mux_a: assert property (@(posedge clk) disable iff (!rstn)
		readSetup(gpd_pkg::IDX_PORT_F_DATA) |=> prdata[gpd_pkg::PORT_F_W-1:0] ==
		(($past(dirF) & $past(latchF)) | (~$past(dirF) & $past(portFPinSync))))
		else $error("port F read mux wrong");
	analog_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		readSetup(gpd_pkg::IDX_PORT_D_DATA) and (ownedD[0] && !dirD[0]) |=> !prdata[0])
		else $error("analog input bit not zero");

	// pin drive
	gpio_drive_a: assert property (@(posedge clk) disable iff (!rstn)
		!ownedF[0] |=> portFPinOeN[0] == !$past(dirF[0]))
		else $error("gpio drive does not follow direction");
	timer_external_clock_pin_float_a: assert property (@(posedge clk) disable iff (!rstn)
		extClkSel |=> portDPinOeN[gpd_pkg::D_TIMER_EXTERNAL_CLOCK_PIN_BIT])
		else $error("timer clock pin driven");
	ss_free_a: assert property (@(posedge clk) disable iff (!rstn)
		spiOn && periphCtrl[gpd_pkg::MSTR_BIT] && !periphCtrl[gpd_pkg::MODE_FAULT_ENABLE_BIT]
		|=> portEPinOeN[4] == !$past(dirE[4]))
		else $error("slave select not gpio");
	sci_tx_a: assert property (@(posedge clk) disable iff (!rstn)
		periphCtrl[gpd_pkg::SCI_BIT] |=> !portEPinOeN[0] && portEPinOut[0] == $past(sciTxOut))
		else $error("transmit pin not driven by serial");
endmodule

// ===== verif/gpd_pin_model.sv
`timescale 1ns/1ps
// pad wires: the outside party drives wherever the device output is off
module gpd_pin_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] pinOut,
	input wire logic [W-1:0] pinOeN,
	input wire logic [W-1:0] extLevel,
	output logic [W-1:0] pinLevel
);
	// an unknown enable counts as off, so a broken enable shows up at once
	always_comb
	begin
		for (int b = 0; b < W; b++)
			pinLevel[b] = (pinOeN[b] === 1'b0) ? pinOut[b] : extLevel[b];
	end
endmodule

// ===== verif/test_gpio_ports_def_shared_pins.sv
`timescale 1ns/1ps
// random port, direction and ownership regression with pin models
module test_gpio_ports_def_shared_pins;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, sciTx, extClk;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rs, ctrl, chan;
	logic [3:0] pstrb, spiOut, spiDrv, tcoF, tcdF, oFN, oFO, pinF;
	logic [1:0] tcoE, tcdE;
	logic [6:0] oDN, oDO, pinD;
	logic [7:0] oEN, oEO, pinE, latD, latE, latF, dirD, dirE, dirF, extD, extE, extF;
	logic [32:0] expQ[$];
	logic [32:0] expN;
	int errorCnt = 0;
	int nCompared = 0;
	int cyc = 0;

	gpd_pin_model #(.W(7)) pmD (.pinOut(oDO), .pinOeN(oDN), .extLevel(extD[6:0]), .pinLevel(pinD));
	gpd_pin_model #(.W(8)) pmE (.pinOut(oEO), .pinOeN(oEN), .extLevel(extE), .pinLevel(pinE));
	gpd_pin_model #(.W(4)) pmF (.pinOut(oFO), .pinOeN(oFN), .extLevel(extF[3:0]), .pinLevel(pinF));

	gpd_ports dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .portDPinIn(pinD), .portDPinOut(oDO), .portDPinOeN(oDN),
		.portEPinIn(pinE), .portEPinOut(oEO), .portEPinOeN(oEN), .portFPinIn(pinF),
		.portFPinOut(oFO), .portFPinOeN(oFN), .spiOut(spiOut), .spiDrv(spiDrv),
		.timerChanOutE(tcoE), .timerChanDrvE(tcdE), .timerChanOutF(tcoF),
		.timerChanDrvF(tcdF), .sciTxOut(sciTx), .portEPinSync(), .portFPinSync(),
		.timerExtClock(extClk), .analogChannelSelect(), .timerPrescalerSelect(),
		.serialPeriphEnable(), .serialPeriphMaster(), .modeFaultEnable(),
		.asyncSerialEnable(), .edgeLevelSelect());

	// clock, 10 ns period
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// xorshift source, fixed start
	function void step();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
	endfunction

	task conclude;
		if (errorCnt == 0 && nCompared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] want);
		nCompared++;
		if (got !== want)
		begin
			errorCnt++;
			$display("CHECK FAILED at %0t got %h want %h", $time, got, want);
		end
	endtask

	// one apb transfer; the expectation is queued before the request goes out
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		expQ.push_back(e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		// a slave that never answers is a mismatch, not a silent skip
		if (pready !== 1'b1)
			errorCnt++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task wreg(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, {idx, 2'b00}, d, 33'h0);
	endtask

	task rreg(input logic [9:0] idx, input logic [31:0] want);
		apb(1'b0, {idx, 2'b00}, 32'h0, {1'b0, want});
	endtask

	// work out pad drive and read-back from the settings, then compare
	task settle;
		logic [7:0] oD, oE, oF, ownD, ownE, ownF, dvE, vlE, pD, pE, pF;
		repeat (5) @(posedge clk);
		ownD = 8'h00;
		if (ctrl[4:0] >= 5'h08 && ctrl[4:0] <= 5'h0E)
			ownD[ctrl[2:0]] = 1'b1;
		if (ctrl[10:8] == 3'h7)
			ownD[6] = 1'b1;
		ownE = {{3{ctrl[16]}}, ctrl[16] & ~(ctrl[17] & ~ctrl[18]), |chan[3:2], |chan[1:0],
			{2{ctrl[19]}}};
		ownF = {4'h0, |chan[11:10], |chan[9:8], |chan[7:6], |chan[5:4]};
		dvE = {spiDrv, tcdE, 2'b01};
		vlE = {spiOut, tcoE, 1'b0, sciTx};
		oD = ownD | ~dirD;
		oE = (ownE & ~dvE) | (~ownE & ~dirE);
		oF = (ownF & ~{4'h0, tcdF}) | (~ownF & ~dirF);
		pD = ~oD & latD;
		pE = ~oE & ((ownE & vlE) | (~ownE & latE));
		pF = ~oF & ((ownF & {4'h0, tcoF}) | (~ownF & latF));
		cmp(32'(oDN), 32'(oD[6:0]));
		cmp(32'(oDO), 32'(pD[6:0]));
		cmp(32'(oEN), 32'(oE));
		cmp(32'(oEO), 32'(pE));
		cmp(32'(oFN), 32'(oF[3:0]));
		cmp(32'(oFO), 32'(pF[3:0]));
		cmp(32'(extClk), 32'((ctrl[10:8] == 3'h7) & extD[6]));
		rreg(gpd_pkg::IDX_PORT_D_DATA, 32'((dirD & latD) | (~dirD & ~ownD & (pD | (oD & extD)))));
		rreg(gpd_pkg::IDX_PORT_E_DATA, 32'((dirE & latE) | (~dirE & (pE | (oE & extE)))));
		rreg(gpd_pkg::IDX_PORT_F_DATA, 32'((dirF & latF) | (~dirF & (pF | (oF & extF)))));
	endtask

	// read-back monitor: oldest note against each completed transfer
	always @(posedge clk)
		if (psel && penable && pready === 1'b1)
		begin
			expN = expQ.pop_front();
			cmp(32'(pslverr), 32'(expN[32]));
			if (!pwrite)
				cmp(prdata, expN[31:0]);
		end

	// hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errorCnt++;
			conclude;
		end
	end

	initial
	begin
		{rstn, psel, penable, pwrite, sciTx} = 5'h00;
		{paddr, pwdata, pstrb, spiOut, spiDrv, tcoE, tcdE, tcoF, tcdF} = 'h0;
		pstrb = 4'hF;
		{latD, latE, latF, dirD, dirE, dirF, extD, extE, extF} = 'h0;
		{ctrl, chan} = 'h0;
		rs = 32'hA4DE1D43;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		settle;
		rreg(gpd_pkg::IDX_PORT_E_DIR, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0, {1'b1, 32'h0});
		apb(1'b0, 12'h00D, 32'h0, {1'b1, 32'h0});
		for (int i = 0; i < 64; i++)
		begin
			step();
			latD = {1'b0, rs[6:0]};
			latE = rs[15:8];
			latF = {4'h0, rs[19:16]};
			extD <= {1'b0, rs[26:20]};
			step();
			extE <= rs[7:0];
			extF <= {4'h0, rs[11:8]};
			{spiOut, spiDrv, tcoE, tcdE, tcoF, tcdF} <= rs[31:12];
			step();
			sciTx <= rs[0];
			dirD = {1'b0, rs[7:1]};
			dirE = rs[15:8];
			dirF = {4'h0, rs[19:16]};
			ctrl = {12'h0, rs[23:20], 5'h0, i[5:3], 3'h0, i[4:0]};
			chan = {20'h0, rs[31:24], rs[3:0]};
			// latch loaded before any direction change
			wreg(gpd_pkg::IDX_PORT_D_DATA, 32'(latD));
			wreg(gpd_pkg::IDX_PORT_E_DATA, 32'(latE));
			wreg(gpd_pkg::IDX_PORT_F_DATA, 32'(latF));
			wreg(gpd_pkg::IDX_PERIPH_CTRL, ctrl);
			wreg(gpd_pkg::IDX_TIMER_CHAN, chan);
			wreg(gpd_pkg::IDX_PORT_D_DIR, 32'(dirD));
			wreg(gpd_pkg::IDX_PORT_E_DIR, 32'(dirE));
			wreg(gpd_pkg::IDX_PORT_F_DIR, 32'(dirF));
			settle;
			if (i == 31)
			begin
				// mid-run reset: directions clear, latches must survive
				rstn <= 1'b0;
				repeat (3) @(posedge clk);
				rstn <= 1'b1;
				@(posedge clk);
				{dirD, dirE, dirF, ctrl, chan} = 'h0;
				settle;
				rreg(gpd_pkg::IDX_PORT_D_DIR, 32'h0);
				dirD = 8'h7F;
				dirE = 8'hFF;
				dirF = 8'h0F;
				wreg(gpd_pkg::IDX_PORT_D_DIR, 32'(dirD));
				wreg(gpd_pkg::IDX_PORT_E_DIR, 32'(dirE));
				wreg(gpd_pkg::IDX_PORT_F_DIR, 32'(dirF));
				settle;
			end
		end
		conclude;
	end
endmodule
